// [rtl/cmb_pkg.sv]
// Package for the CAN message buffer RAM: layout, field positions, carriers
// What this block does
// - Thirty-two buffers, identical eight-word layout
// - Base identifier bits 12:2, bits 15:13 zero
// - Bit 1 of base word: substitute remote
// - Bit 0 of base word: send extended identifier
// - Extended id split: word bits 11:0, length 15:10
// - Length word bit 9: remote transmission request
// - Length code bits 3:0, bits 7:5 zero
// - Eight bytes, two per word, even byte low
// - Receive writes matched filter in status 12:8
// - Buffers live in DMA RAM, not registers
package cmb_pkg;
  localparam int NUM_BUFS = 32;
  localparam int WORDS_PER_BUF = 8;
  localparam int ADDR_W = 8;
  localparam int FIFO_DEPTH = 8;
  // Word index inside one buffer
  localparam logic [2:0] W_BASE_ID = 3'h0;
  localparam logic [2:0] W_EXT_ID = 3'h1;
  localparam logic [2:0] W_LEN_CTRL = 3'h2;
  localparam logic [2:0] W_DATA0 = 3'h3;
  localparam logic [2:0] W_STATUS = 3'h7;
  // Storable bits of each word; the rest reads zero
  localparam logic [15:0] MASK_BASE_ID = 16'h1FFF;
  localparam logic [15:0] MASK_EXT_ID = 16'h0FFF;
  localparam logic [15:0] MASK_LEN_CTRL = 16'hFF1F;
  localparam logic [15:0] MASK_STATUS = 16'h1F00;
  localparam logic [15:0] MASK_DATA = 16'hFFFF;
  // Field positions
  localparam int SID_LSB = 2;
  localparam int SID_MSB = 12;
  localparam int SRR_BIT = 1;
  localparam int IDE_BIT = 0;
  localparam int EID_HI_MSB = 11;
  localparam int EID_LO_LSB = 10;
  localparam int RTR_BIT = 9;
  localparam int RSV1_BIT = 8;
  localparam int RSV0_BIT = 4;
  localparam int FILT_LSB = 8;
  localparam logic [3:0] MAX_BYTES = 4'h8;

  typedef enum logic [2:0] {F_BASE, F_FLAGS, F_EXT, F_CTRL, F_DATA} cmb_field_t;

  // One serialised field towards the protocol engine, right-aligned value
  typedef struct packed {
    cmb_field_t field;
    logic [17:0] value;
  } cmb_tx_item_t;

  // One word stored by the receive side
  typedef struct packed {
    logic [4:0] bidx;
    logic [2:0] word;
    logic [15:0] data;
    logic [4:0] filter;
  } cmb_rx_word_t;
endpackage : cmb_pkg

// [rtl/cmb_buffer.sv]
// Message buffer RAM with DMA port, receive store and transmit serialiser
`timescale 1ns/1ns

module cmb_fifo #(
  parameter int WIDTH = 21,
  parameter int DEPTH = 8
) (
  // Clock, reset, enable
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire logic i_ce,
  // Fill side
  input wire logic i_in_valid,
  input wire logic [WIDTH-1:0] i_in_data,
  output logic o_in_ready,
  // Drain side
  output logic o_out_valid,
  output logic [WIDTH-1:0] o_out_data,
  input wire logic i_out_ready
);
  localparam int PW = $clog2(DEPTH);
  logic [WIDTH-1:0] store_ff [DEPTH];
  logic [PW:0] wr_ptr_ff;
  logic [PW:0] rd_ptr_ff;
  logic full;
  logic empty;
  logic do_wr;
  logic do_rd;

  // Extra pointer bit tells full from empty
  assign empty = (wr_ptr_ff == rd_ptr_ff);
  assign full = (wr_ptr_ff[PW] != rd_ptr_ff[PW]) && (wr_ptr_ff[PW-1:0] == rd_ptr_ff[PW-1:0]);
  assign o_in_ready = i_ce && !full;
  assign o_out_valid = i_ce && !empty;
  assign o_out_data = store_ff[rd_ptr_ff[PW-1:0]];
  assign do_wr = i_in_valid && o_in_ready;
  assign do_rd = o_out_valid && i_out_ready;

  // Storage, no reset needed: read only behind the pointers
  always_ff @(posedge i_clk)
  begin
    if (do_wr)
      store_ff[wr_ptr_ff[PW-1:0]] <= i_in_data;
  end

  // Pointers
  always_ff @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
    end
    else
    begin
      if (do_wr)
        wr_ptr_ff <= wr_ptr_ff + 1'b1;
      if (do_rd)
        rd_ptr_ff <= rd_ptr_ff + 1'b1;
    end
  end
endmodule : cmb_fifo

module cmb_buffer (
  // Clock, reset, enable
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire logic i_ce,
  // DMA / CPU access to the buffer RAM
  input wire logic i_dma_req,
  input wire logic i_dma_we,
  input wire logic [7:0] i_dma_addr,
  input wire logic [15:0] i_dma_wdata,
  input wire logic [1:0] i_dma_be,
  output logic o_dma_ack,
  output logic [15:0] o_dma_rdata,
  // Receive store from the protocol engine
  input wire logic i_rx_valid,
  input wire cmb_pkg::cmb_rx_word_t i_rx_word,
  // Transmit request
  input wire logic i_tx_start,
  input wire logic [4:0] i_tx_buf,
  output logic o_tx_busy,
  // Serialised transmit fields
  output logic o_tx_valid,
  output cmb_pkg::cmb_tx_item_t o_tx_item,
  input wire logic i_tx_ready
);
  typedef enum logic [2:0] {T_IDLE, T_BASE, T_FLAGS, T_EXT, T_CTRL, T_DATA} cmb_tx_state_t;

  // Buffer RAM, word address = buffer * 8 + word index
  logic [15:0] mem [cmb_pkg::NUM_BUFS * cmb_pkg::WORDS_PER_BUF];
  logic [15:0] o_dma_rdata_ff;
  logic wr_en;
  logic [7:0] wr_addr;
  logic [15:0] wr_val;
  logic [15:0] dma_merged;
  cmb_tx_state_t state_ff;
  cmb_tx_state_t nxt_state;
  logic [4:0] tx_buf_ff;
  logic [2:0] byte_idx_ff;
  logic [15:0] base_w;
  logic [15:0] ext_w;
  logic [15:0] len_w;
  logic [15:0] data_w;
  logic [3:0] nbytes;
  logic push;
  logic fifo_ready;
  cmb_pkg::cmb_tx_item_t item;

  function automatic logic [15:0] word_mask(input logic [2:0] w);
    case (w)
      cmb_pkg::W_BASE_ID: word_mask = cmb_pkg::MASK_BASE_ID;
      cmb_pkg::W_EXT_ID: word_mask = cmb_pkg::MASK_EXT_ID;
      cmb_pkg::W_LEN_CTRL: word_mask = cmb_pkg::MASK_LEN_CTRL;
      cmb_pkg::W_STATUS: word_mask = cmb_pkg::MASK_STATUS;
      default: word_mask = cmb_pkg::MASK_DATA;
    endcase
  endfunction : word_mask

  // Receive side wins the write port; DMA waits a cycle, seen as no ack
  assign o_dma_ack = i_ce && i_dma_req && !i_rx_valid;
  assign dma_merged = {i_dma_be[1] ? i_dma_wdata[15:8] : mem[i_dma_addr][15:8],
                       i_dma_be[0] ? i_dma_wdata[7:0] : mem[i_dma_addr][7:0]};

  // Write port selection; unimplemented bits are never stored
  always_comb
  begin
    wr_en = 1'b0;
    wr_addr = i_dma_addr;
    wr_val = dma_merged & word_mask(i_dma_addr[2:0]);
    if (i_ce && i_rx_valid)
    begin
      wr_en = 1'b1;
      wr_addr = {i_rx_word.bidx, i_rx_word.word};
      if (i_rx_word.word == cmb_pkg::W_STATUS)
        wr_val = 16'({11'h000, i_rx_word.filter} << cmb_pkg::FILT_LSB);
      else
        wr_val = i_rx_word.data & word_mask(i_rx_word.word);
    end
    else if (o_dma_ack && i_dma_we)
      wr_en = 1'b1;
  end

  // RAM contents are undefined after reset, like the real buffer memory
  always_ff @(posedge i_clk)
  begin
    if (wr_en)
      mem[wr_addr] <= wr_val;
  end

  // Registered read data, one cycle after the ack
  always_ff @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
      o_dma_rdata_ff <= 16'h0000;
    else if (o_dma_ack && !i_dma_we)
      o_dma_rdata_ff <= mem[i_dma_addr];
  end
  assign o_dma_rdata = o_dma_rdata_ff;

  // Live view of the buffer being sent; software must not rewrite it meanwhile
  assign base_w = mem[{tx_buf_ff, cmb_pkg::W_BASE_ID}];
  assign ext_w = mem[{tx_buf_ff, cmb_pkg::W_EXT_ID}];
  assign len_w = mem[{tx_buf_ff, cmb_pkg::W_LEN_CTRL}];
  assign data_w = mem[{tx_buf_ff, cmb_pkg::W_DATA0 + {1'b0, byte_idx_ff[2:1]}}];
  assign nbytes = (len_w[3:0] > cmb_pkg::MAX_BYTES) ? cmb_pkg::MAX_BYTES : len_w[3:0];
  assign push = (state_ff != T_IDLE) && fifo_ready;
  assign o_tx_busy = (state_ff != T_IDLE);

  // Field being emitted in the current state
  always_comb
  begin
    item.field = cmb_pkg::F_BASE;
    item.value = '0;
    case (state_ff)
      T_BASE: item.value = {7'h00, base_w[cmb_pkg::SID_MSB:cmb_pkg::SID_LSB]};
      T_FLAGS:
      begin
        item.field = cmb_pkg::F_FLAGS;
        item.value = {16'h0000, base_w[cmb_pkg::SRR_BIT], base_w[cmb_pkg::IDE_BIT]};
      end
      T_EXT:
      begin
        item.field = cmb_pkg::F_EXT;
        item.value = {ext_w[cmb_pkg::EID_HI_MSB:0], len_w[15:cmb_pkg::EID_LO_LSB]};
      end
      T_CTRL:
      begin
        item.field = cmb_pkg::F_CTRL;
        item.value = {11'h000, len_w[cmb_pkg::RTR_BIT], len_w[cmb_pkg::RSV1_BIT],
                      len_w[cmb_pkg::RSV0_BIT], len_w[3:0]};
      end
      T_DATA:
      begin
        item.field = cmb_pkg::F_DATA;
        item.value = {10'h000, byte_idx_ff[0] ? data_w[15:8] : data_w[7:0]};
      end
      default: item.value = '0;
    endcase
  end

  // Frame order: base, flags, extension only when selected, control, bytes
  always_comb
  begin
    nxt_state = state_ff;
    case (state_ff)
      T_IDLE: if (i_ce && i_tx_start) nxt_state = T_BASE;
      T_BASE: if (push) nxt_state = T_FLAGS;
      T_FLAGS: if (push) nxt_state = base_w[cmb_pkg::IDE_BIT] ? T_EXT : T_CTRL;
      T_EXT: if (push) nxt_state = T_CTRL;
      T_CTRL: if (push) nxt_state = (nbytes == 4'h0) ? T_IDLE : T_DATA;
      T_DATA: if (push && ({1'b0, byte_idx_ff} == nbytes - 4'h1)) nxt_state = T_IDLE;
      default: nxt_state = T_IDLE;
    endcase
  end

  // Serialiser state
  always_ff @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
      state_ff <= T_IDLE;
    else if (i_ce)
      state_ff <= nxt_state;
  end

  // Buffer index latched at start, byte counter ascending
  always_ff @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      tx_buf_ff <= 5'h00;
      byte_idx_ff <= 3'h0;
    end
    else if (i_ce)
    begin
      if (state_ff == T_IDLE && i_tx_start)
      begin
        tx_buf_ff <= i_tx_buf;
        byte_idx_ff <= 3'h0;
      end
      else if (push && state_ff == T_DATA)
        byte_idx_ff <= byte_idx_ff + 3'h1;
    end
  end

  // Output FIFO; a stalled engine back-pressures the serialiser
  cmb_fifo #(.WIDTH($bits(cmb_pkg::cmb_tx_item_t)), .DEPTH(cmb_pkg::FIFO_DEPTH)) u_fifo (
    .i_clk(i_clk),
    .i_resetn(i_resetn),
    .i_ce(i_ce),
    .i_in_valid(push),
    .i_in_data(item),
    .o_in_ready(fifo_ready),
    .o_out_valid(o_tx_valid),
    .o_out_data(o_tx_item),
    .i_out_ready(i_tx_ready)
  );

  // Checks
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_resetn);

  sequence s_start;
    i_ce && i_tx_start && state_ff == T_IDLE;
  endsequence
  sequence s_base;
    state_ff == T_BASE && o_tx_busy;
  endsequence
  sequence s_rd(logic [2:0] w);
    o_dma_ack && !i_dma_we && i_dma_addr[2:0] == w;
  endsequence

  a_frame_starts_base: assert property (s_start |=> s_base)
    else $error("transmit did not start with base identifier");
  a_sid_upper_zero: assert property (s_rd(cmb_pkg::W_BASE_ID) |=> o_dma_rdata[15:13] == 3'h0)
    else $error("base word upper bits not zero");
  a_eid_upper_zero: assert property (s_rd(cmb_pkg::W_EXT_ID) |=> o_dma_rdata[15:12] == 4'h0)
    else $error("extended word upper bits not zero");
  a_len_gap_zero: assert property (s_rd(cmb_pkg::W_LEN_CTRL) |=> o_dma_rdata[7:5] == 3'h0)
    else $error("length word bits 7:5 not zero");
  a_status_filter_only: assert property (s_rd(cmb_pkg::W_STATUS)
    |=> (o_dma_rdata & ~cmb_pkg::MASK_STATUS) == 16'h0000)
    else $error("status word holds bits outside filter field");
  a_filter_stored: assert property (i_ce && i_rx_valid && i_rx_word.word == cmb_pkg::W_STATUS
    |=> mem[$past(wr_addr)][12:8] == $past(i_rx_word.filter))
    else $error("matched filter number not stored");
  a_ext_only_ide: assert property (push && state_ff == T_EXT |-> base_w[cmb_pkg::IDE_BIT])
    else $error("extended identifier sent without extension flag");
  a_srr_flag_sent: assert property (push && state_ff == T_FLAGS |-> item.value[1] == base_w[cmb_pkg::SRR_BIT])
    else $error("substitute remote flag mismatch");
  a_rtr_flag_sent: assert property (push && state_ff == T_CTRL |-> item.value[6] == len_w[cmb_pkg::RTR_BIT])
    else $error("remote request flag mismatch");
  a_byte_bound: assert property (push && state_ff == T_DATA |-> {1'b0, byte_idx_ff} < nbytes)
    else $error("data byte beyond coded length");
endmodule : cmb_buffer

// [verification/cmb_engine_model.sv]
// Protocol engine stand-in: stalling transmit sink and receive word source
`timescale 1ns/1ns
module cmb_engine_model (
  // Clock
  input wire logic i_clk,
  // Transmit sink
  output logic o_tx_ready,
  // Receive store
  output logic o_rx_valid,
  output cmb_pkg::cmb_rx_word_t o_rx_word
);
  logic go = 1'b0;
  cmb_pkg::cmb_rx_word_t pend;
  // Quiet outputs from time zero
  initial
  begin
    o_tx_ready = 1'b0;
    o_rx_valid = 1'b0;
    o_rx_word = '0;
  end
  // Random stalls so the FIFO fills and refuses; idle word toggles, never stale
  always @(posedge i_clk)
  begin
    o_tx_ready <= ($urandom_range(3) != 0);
    o_rx_valid <= go;
    o_rx_word <= go ? pend : ~o_rx_word;
    go = 1'b0;
  end
  // One stored word; set up on the falling edge to stay clear of the sampling edge
  task automatic store(input cmb_pkg::cmb_rx_word_t w);
    @(negedge i_clk);
    pend = w;
    go = 1'b1;
    @(posedge i_clk);
    @(posedge i_clk);
  endtask : store
endmodule : cmb_engine_model

// [verification/cmb_buffer_tb.sv]
// Self-checking bench for the message buffer RAM and its transmit serialiser
`timescale 1ns/1ns
module cmb_buffer_tb;
  logic clk = 1'b0, rstn = 1'b0, ce = 1'b1, req = 1'b0, we = 1'b0, start = 1'b0, rd_due = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [15:0] wdata = 16'h0000;
  logic [1:0] be = 2'h3;
  logic [4:0] tbuf = 5'h00;
  logic ack, busy, tvalid, tready, rvalid;
  logic [15:0] rdata;
  cmb_pkg::cmb_tx_item_t titem, nil_item = '1;
  cmb_pkg::cmb_rx_word_t rword;
  logic [15:0] mem [256];
  logic [15:0] rq [$];
  cmb_pkg::cmb_tx_item_t tq [$];
  int fail_count = 0, n_tests = 0, cyc = 0;
  // 25 MHz clock
  initial forever #20 clk = ~clk;
  cmb_buffer dut_u (.i_clk(clk), .i_resetn(rstn), .i_ce(ce), .i_dma_req(req), .i_dma_we(we),
    .i_dma_addr(addr), .i_dma_wdata(wdata), .i_dma_be(be), .o_dma_ack(ack), .o_dma_rdata(rdata),
    .i_rx_valid(rvalid), .i_rx_word(rword), .i_tx_start(start), .i_tx_buf(tbuf), .o_tx_busy(busy),
    .o_tx_valid(tvalid), .o_tx_item(titem), .i_tx_ready(tready));
  cmb_engine_model eng_u (.i_clk(clk), .o_tx_ready(tready), .o_rx_valid(rvalid), .o_rx_word(rword));
  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : stop_test
  task automatic cmp_word(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      fail_count++;
      $display("[FAIL] %0t word %h expected %h", $time, got, exp);
    end
  endtask : cmp_word
  task automatic cmp_item(input cmb_pkg::cmb_tx_item_t got, input cmb_pkg::cmb_tx_item_t exp);
    n_tests++;
    if (got !== exp)
    begin
      fail_count++;
      $display("[FAIL] %0t item %h expected %h", $time, got, exp);
    end
  endtask : cmp_item
  // Storable bits of each word, from the layout constants
  function automatic logic [15:0] wmask(input logic [2:0] w);
    case (w)
      cmb_pkg::W_BASE_ID: return cmb_pkg::MASK_BASE_ID;
      cmb_pkg::W_EXT_ID: return cmb_pkg::MASK_EXT_ID;
      cmb_pkg::W_LEN_CTRL: return cmb_pkg::MASK_LEN_CTRL;
      cmb_pkg::W_STATUS: return cmb_pkg::MASK_STATUS;
      default: return cmb_pkg::MASK_DATA;
    endcase
  endfunction : wmask
  // One access, held until acknowledged; reads leave their expectation in the queue
  task automatic dma(input logic w, input logic [7:0] a, input logic [15:0] d, input logic [1:0] b);
    logic [15:0] bm;
    bm = {{8{b[1]}}, {8{b[0]}}};
    req <= 1'b1;
    we <= w;
    addr <= a;
    wdata <= d;
    be <= b;
    if (w)
      mem[a] = (mem[a] & ~bm | d & bm) & wmask(a[2:0]);
    else
      rq.push_back(mem[a]);
    for (int n = 0; n < 50; n++)
    begin
      @(posedge clk);
      if (ack === 1'b1)
        break;
    end
    // A refused access that never ends counts against the run
    if (ack !== 1'b1)
    begin
      fail_count++;
      $display("[FAIL] %0t access at %h never acknowledged", $time, a);
    end
    req <= 1'b0;
    @(posedge clk);
  endtask : dma
  // Receive word through the engine model
  task automatic rx(input logic [4:0] b, input logic [2:0] w, input logic [15:0] d, input logic [4:0] f);
    mem[{b, w}] = (w == cmb_pkg::W_STATUS) ? {3'h0, f, 8'h00} : d & wmask(w);
    eng_u.store('{b, w, d, f});
  endtask : rx
  // Compose a buffer, send it, poke a refused start and a clock-enable pause
  task automatic send(input logic [4:0] b, input logic ide, input logic [3:0] dlc);
    logic [10:0] sid;
    logic [17:0] eid;
    logic srr, rtr;
    logic [15:0] dw;
    sid = 11'($urandom);
    eid = 18'($urandom);
    srr = 1'($urandom);
    rtr = 1'($urandom);
    dma(1'b1, {b, 3'h0}, {3'h0, sid, srr, ide}, 2'h3);
    dma(1'b1, {b, 3'h1}, {4'h0, eid[17:6]}, 2'h3);
    dma(1'b1, {b, 3'h2}, {eid[5:0], rtr, 1'b0, 3'h0, 1'b0, dlc}, 2'h3);
    for (int j = 3; j < 7; j++) dma(1'b1, {b, 3'(j)}, 16'($urandom), 2'h3);
    tq.push_back('{cmb_pkg::F_BASE, 18'(sid)});
    tq.push_back('{cmb_pkg::F_FLAGS, 18'({srr, ide})});
    if (ide) tq.push_back('{cmb_pkg::F_EXT, eid});
    tq.push_back('{cmb_pkg::F_CTRL, 18'({rtr, 2'h0, dlc})});
    for (int j = 0; j < ((dlc > 8) ? 8 : dlc); j++)
    begin
      dw = mem[{b, 3'(3 + j / 2)}];
      tq.push_back('{cmb_pkg::F_DATA, 18'(j[0] ? dw[15:8] : dw[7:0])});
    end
    start <= 1'b1;
    tbuf <= b;
    @(posedge clk);
    tbuf <= ~b;
    @(posedge clk);
    start <= 1'b0;
    ce <= 1'b0;
    repeat (2) @(posedge clk);
    cmp_word({15'h0000, tvalid}, 16'h0000);
    ce <= 1'b1;
    for (int n = 0; n < 300 && (busy !== 1'b0 || tq.size() != 0); n++) @(posedge clk);
    cmp_word(16'(tq.size()), 16'h0000);
  endtask : send
  // Watcher: read data one cycle after a read ack, transmit items on valid and ready
  always @(posedge clk)
  begin
    if (rd_due) cmp_word(rdata, rq.size() ? rq.pop_front() : 16'hXXXX);
    rd_due <= ack && !we;
    if (tvalid === 1'b1 && tready === 1'b1) cmp_item(titem, tq.size() ? tq.pop_front() : nil_item);
    cyc++;
    if (cyc == 20000)
    begin
      fail_count++;
      stop_test();
    end
  end
  // Main sequence
  initial
  begin
    void'($urandom(32'h0000B52F));
    repeat (2) @(posedge clk);
    cmp_word({rdata[15:2], busy, tvalid}, 16'h0000);
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    // All ones written to every word of buffer 9: unimplemented bits must read zero
    for (int i = 0; i < 8; i++) dma(1'b1, {5'h09, 3'(i)}, 16'hFFFF, 2'h3);
    for (int i = 0; i < 8; i++) dma(1'b0, {5'h1F - 5'h16, 3'(i)}, 16'h0000, 2'h0);
    // Single byte lanes of two payload words
    dma(1'b1, 8'h4B, 16'h1234, 2'h1);
    dma(1'b1, 8'h4C, 16'h5678, 2'h2);
    dma(1'b0, 8'h4B, 16'h0000, 2'h0);
    dma(1'b0, 8'h4C, 16'h0000, 2'h0);
    // Matched filter numbers, including both ends of the field
    for (int i = 0; i < 3; i++)
    begin
      rx(5'(i), 3'h7, 16'($urandom), (i == 0) ? 5'h00 : (i == 1) ? 5'h1F : 5'($urandom));
      dma(1'b0, {5'(i), 3'h7}, 16'h0000, 2'h0);
    end
    rx(5'h02, 3'h0, 16'hFFFF, 5'h03);
    dma(1'b0, 8'h10, 16'h0000, 2'h0);
    // A receive write racing a read of the same word: the read must wait
    dma(1'b1, 8'h13, 16'hAAAA, 2'h3);
    fork
      rx(5'h02, 3'h3, 16'h5555, 5'h00);
      begin
        @(posedge clk);
        dma(1'b0, 8'h13, 16'h0000, 2'h0);
      end
    join
    // Both identifier kinds, length codes 0, 8, 15 and random, first and last buffer
    for (int i = 0; i < 8; i++)
      send((i == 7) ? 5'h1F : 5'(i), i[0],
        (i % 4 == 0) ? 4'h0 : (i % 4 == 1) ? 4'h8 : (i % 4 == 2) ? 4'hF : 4'($urandom));
    repeat (2) @(posedge clk);
    cmp_word(16'(rq.size()), 16'h0000);
    stop_test();
  end
endmodule : cmb_buffer_tb
